// ===== cop_pkg.sv
package cop_pkg;

	// ----------------------------------------------------------------
	// Port map of the coprocessor and its control ports
	// ----------------------------------------------------------------
	localparam logic [7:0] PORT_CP0 = 8'hF8;
	localparam logic [7:0] PORT_CP1 = 8'hFA;
	localparam logic [7:0] PORT_CP2 = 8'hFC;
	localparam logic [7:0] PORT_BUSY_CLR = 8'hF0;
	localparam logic [7:0] PORT_CP_RESET = 8'hF1;
	localparam logic [15:0] RDATA_FLOAT = 16'hFFFF;
	localparam logic [15:0] DATA_ZERO = 16'h0000;

	// ----------------------------------------------------------------
	// Timing of the coprocessor reset pulse
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int CP_RESET_NS = 200;
	localparam int CP_RESET_CYCLES = (CP_RESET_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// Decoded kind of an I/O port address
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PC_COPROC = 2'b00,
		PC_CLEAR = 2'b01,
		PC_RESET = 2'b10,
		PC_NONE = 2'b11
	} port_class_e;

	// ----------------------------------------------------------------
	// Controller registers on APB
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] REG_IRQ_CLR = 8'h18;
	localparam logic [7:0] REG_IRQ_EN = 8'h1C;
	localparam int CTRL_GO = 0;
	localparam int CTRL_WR = 1;
	localparam int CTRL_BYTE = 2;
	localparam int STAT_PEND = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_ERRB = 2;
	localparam int EV_DONE = 0;
	localparam int EV_ERRB = 1;
	localparam int EV_IDLE = 2;
	localparam int EV_W = 3;

endpackage

// ===== cop_link_if.sv
`timescale 1ns/1ps
// Host-side I/O cycles towards the coprocessor glue logic.
interface cop_link_if;
	logic req; // I/O cycle request, held until ack.
	logic wr; // High for an output, low for an input.
	logic byte8; // High for an 8-bit cycle.
	logic [7:0] addr; // I/O port address.
	logic [15:0] wdata; // Output data.
	logic [15:0] rdata; // Input data, valid with ack.
	logic ack; // One-cycle end of an I/O cycle.
	logic busy; // Coprocessor busy.
	logic err_busy; // Busy condition latched on error.

	modport host (
		output req,
		output wr,
		output byte8,
		output addr,
		output wdata,
		input rdata,
		input ack,
		input busy,
		input err_busy
	);
	modport dev (
		input req,
		input wr,
		input byte8,
		input addr,
		input wdata,
		output rdata,
		output ack,
		output busy,
		output err_busy
	);
endinterface

// ===== port_decode.sv
`timescale 1ns/1ps
// Sorts an I/O address into coprocessor port, control port or none.
module port_decode (
	input wire logic [7:0] addr, // I/O port address.
	output cop_pkg::port_class_e cls, // Kind of port.
	output logic [1:0] idx // Coprocessor port index.
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Each coprocessor port is one word apart, so bits 2:1 select it.
	always_comb begin
		idx = addr[2:1];
		unique case (addr)
			cop_pkg::PORT_CP0, cop_pkg::PORT_CP1, cop_pkg::PORT_CP2: begin
				cls = cop_pkg::PC_COPROC;
			end
			cop_pkg::PORT_BUSY_CLR: begin
				cls = cop_pkg::PC_CLEAR;
			end
			cop_pkg::PORT_CP_RESET: begin
				cls = cop_pkg::PC_RESET;
			end
			default: begin
				cls = cop_pkg::PC_NONE;
			end
		endcase
	end

endmodule

// ===== cop_glue.sv
`timescale 1ns/1ps
// Contract
// - Coprocessor decoded at three I/O port addresses.
// - Results read back through those same ports.
// - Host waits while busy is asserted before coprocessor port cycles only.
// - Error output latches a separate busy condition.
// - 8-bit output to clear port clears latch.
// - 8-bit output to reset port resets coprocessor.
module cop_glue #(
	parameter int RESET_CYCLES = cop_pkg::CP_RESET_CYCLES
) (
	input wire logic clk, // System clock.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic ce, // Clock enable, freezes all state when low.
	cop_link_if.dev link, // I/O cycles from the host.
	output logic cp_sel, // Coprocessor port select.
	output logic cp_wr, // Coprocessor port write strobe.
	output logic cp_rd, // Coprocessor port read strobe.
	output logic [1:0] cp_idx, // Coprocessor port index.
	output logic cp_byte, // 8-bit access to the coprocessor.
	output logic [15:0] cp_wdata, // Opcode or operand.
	input wire logic [15:0] cp_rdata, // Result, valid while cp_rd.
	input wire logic cp_busy, // Coprocessor busy, active high.
	input wire logic cp_error_n, // Coprocessor error, active low.
	output logic cp_reset // Coprocessor reset to real mode.
);

	// ----------------------------------------------------------------
	// Types and state
	// ----------------------------------------------------------------
	// Counter width fits the whole reset pulse length.
	localparam int CW = $clog2(RESET_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(RESET_CYCLES - 1);
	localparam logic [CW-1:0] CNT_ZERO = '0;

	// Cycle sequencer states; the spare codes fall back to reset.
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_STROBE = 3'b001,
		D_HOLD = 3'b010,
		D_RESET = 3'b011
	} dev_state_e;

	// Every flip-flop of the block lives in this one struct.
	typedef struct packed {
		dev_state_e st;
		logic [CW-1:0] cnt;
		logic sel;
		logic wr;
		logic rd;
		logic [1:0] idx;
		logic byte8;
		logic [15:0] wdata;
		logic rst;
		logic ack;
		logic [15:0] rdata;
		logic busy;
		logic errb;
	} dev_s;

	// Reset clears the strobes, the pulse and the busy latch alike.
	localparam dev_s DEV_RST = '0;

	dev_s s_reg;
	dev_s s_next;
	// Decode results for the request now on the link.
	cop_pkg::port_class_e cls;
	logic [1:0] idx;
	logic ctl_write;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Sorts the address of the request now on the link.
	port_decode port_decode_i (
		.addr(link.addr),
		.cls(cls),
		.idx(idx)
	);

	// Control ports only act on 8-bit output cycles.
	assign ctl_write = link.wr && link.byte8;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Runs one I/O cycle at a time and keeps the busy latch.
	always_comb begin
		s_next = s_reg;
		// The ack falls back each cycle unless a state raises it; the strobes and the reset pulse are cleared by their states.
		s_next.ack = 1'b0;
		s_next.busy = cp_busy;
		unique case (s_reg.st)
			D_IDLE: begin
				// A new cycle is only taken once the last one was released.
				if (link.req) begin
					// Only control and unknown ports answer with a floating bus.
					s_next.rdata = cop_pkg::RDATA_FLOAT;
					unique case (cls)
						cop_pkg::PC_COPROC: begin
							// Opcodes and operands go out, results come in.
							s_next.sel = 1'b1;
							s_next.wr = link.wr;
							s_next.rd = !link.wr;
							s_next.idx = idx;
							s_next.byte8 = link.byte8;
							s_next.wdata = link.wdata;
							s_next.st = D_STROBE;
						end
						cop_pkg::PC_CLEAR: begin
							// The written value itself is never looked at.
							if (ctl_write) begin
								s_next.errb = 1'b0;
							end
							s_next.ack = 1'b1;
							s_next.st = D_HOLD;
						end
						cop_pkg::PC_RESET: begin
							// Only an 8-bit output starts the pulse; others are just answered.
							if (ctl_write) begin
								s_next.rst = 1'b1;
								s_next.cnt = CNT_LOAD;
								s_next.st = D_RESET;
							end else begin
								s_next.ack = 1'b1;
								s_next.st = D_HOLD;
							end
						end
						cop_pkg::PC_NONE: begin
							// Unknown ports answer at once with a floating bus.
							s_next.ack = 1'b1;
							s_next.st = D_HOLD;
						end
					endcase
				end
			end
			D_STROBE: begin
				// The strobe stood for one cycle; read data is taken now.
				s_next.sel = 1'b0;
				s_next.wr = 1'b0;
				s_next.rd = 1'b0;
				if (s_reg.rd) begin
					s_next.rdata = cp_rdata;
				end else begin
					// Output cycles hand back zero as their data.
					s_next.rdata = cop_pkg::DATA_ZERO;
				end
				s_next.ack = 1'b1;
				s_next.st = D_HOLD;
			end
			D_HOLD: begin
				// Waits for the host to drop its request after the ack.
				if (!link.req) begin
					s_next.st = D_IDLE;
				end
			end
			D_RESET: begin
				// Holds the reset pulse for its full length, then answers.
				if (s_reg.cnt == CNT_ZERO) begin
					s_next.rst = 1'b0;
					s_next.ack = 1'b1;
					s_next.st = D_HOLD;
				end else begin
					// The counter runs down once per enabled clock.
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			default: begin
				s_next = DEV_RST;
			end
		endcase
		// An error sets the latch, and a set wins over a clear.
		if (!cp_error_n) begin
			s_next.errb = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset clears the busy latch; the clock enable freezes everything.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_reg <= DEV_RST;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a field of the state register.
	assign cp_sel = s_reg.sel;
	assign cp_wr = s_reg.wr;
	assign cp_rd = s_reg.rd;
	assign cp_idx = s_reg.idx;
	assign cp_byte = s_reg.byte8;
	assign cp_wdata = s_reg.wdata;
	assign cp_reset = s_reg.rst;

	// The latched condition travels on its own line beside busy.
	assign link.ack = s_reg.ack;
	assign link.rdata = s_reg.rdata;
	assign link.busy = s_reg.busy;
	assign link.err_busy = s_reg.errb;

endmodule

// ===== cop_host.sv
`timescale 1ns/1ps
// Issues coprocessor I/O cycles on orders given over APB.
module cop_host (
	input wire logic clk, // System clock.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic ce, // Clock enable, freezes all state when low.
	cop_link_if.host link, // I/O cycles to the glue logic.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	output logic irq // Level interrupt.
);

	// ----------------------------------------------------------------
	// Types and state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_WAIT = 2'b01,
		H_REQ = 2'b10
	} host_state_e;

	typedef struct packed {
		host_state_e st;
		logic pend;
		logic req;
		logic wr;
		logic byte8;
		logic [7:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [cop_pkg::EV_W-1:0] ev;
		logic [cop_pkg::EV_W-1:0] en;
		logic busy_q;
		logic errb_q;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} host_s;

	localparam host_s HOST_RST = '0;

	host_s s_reg;
	host_s s_next;
	cop_pkg::port_class_e cls;
	logic busy_any;
	logic setup;
	logic access;

	// ----------------------------------------------------------------
	// Target decode
	// ----------------------------------------------------------------
	// Tells coprocessor ports from control ports for the wait.
	port_decode port_decode_i (
		.addr(s_reg.addr),
		.cls(cls),
		.idx()
	);

	assign busy_any = link.busy || link.err_busy;
	assign setup = psel && !penable;
	assign access = psel && penable && s_reg.pready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// APB slave with no wait states, then the I/O cycle sequencer.
	always_comb begin
		s_next = s_reg;
		s_next.pready = setup;
		s_next.busy_q = busy_any;
		s_next.errb_q = link.err_busy;
		if (setup) begin
			s_next.pslverr = 1'b0;
			s_next.prdata = '0;
			unique case (paddr)
				cop_pkg::REG_CTRL: s_next.prdata = {29'h0, s_reg.byte8, s_reg.wr, 1'b0};
				cop_pkg::REG_ADDR: s_next.prdata = {24'h0, s_reg.addr};
				cop_pkg::REG_WDATA: s_next.prdata = {16'h0, s_reg.wdata};
				cop_pkg::REG_RDATA: s_next.prdata = {16'h0, s_reg.rdata};
				cop_pkg::REG_STATUS: s_next.prdata = {29'h0, link.err_busy, link.busy, s_reg.pend};
				cop_pkg::REG_IRQ_STAT: s_next.prdata = {29'h0, s_reg.ev};
				cop_pkg::REG_IRQ_CLR: s_next.prdata = '0;
				cop_pkg::REG_IRQ_EN: s_next.prdata = {29'h0, s_reg.en};
				default: s_next.pslverr = 1'b1;
			endcase
		end
		if (access && pwrite) begin
			unique case (paddr)
				cop_pkg::REG_CTRL: begin
					// An order given while one is pending is ignored.
					if (!s_reg.pend) begin
						s_next.wr = pwdata[cop_pkg::CTRL_WR];
						s_next.byte8 = pwdata[cop_pkg::CTRL_BYTE];
						if (pwdata[cop_pkg::CTRL_GO]) begin
							s_next.pend = 1'b1;
							s_next.st = H_WAIT;
						end
					end
				end
				// Address and data stay put while a cycle is pending on the link.
				cop_pkg::REG_ADDR: begin
					if (!s_reg.pend) begin
						s_next.addr = pwdata[7:0];
					end
				end
				cop_pkg::REG_WDATA: begin
					if (!s_reg.pend) begin
						s_next.wdata = pwdata[15:0];
					end
				end
				cop_pkg::REG_IRQ_CLR: s_next.ev = s_reg.ev & ~pwdata[cop_pkg::EV_W-1:0];
				cop_pkg::REG_IRQ_EN: s_next.en = pwdata[cop_pkg::EV_W-1:0];
				default: begin
				end
			endcase
		end
		unique case (s_reg.st)
			H_IDLE: begin
			end
			H_WAIT: begin
				// Coprocessor work waits for busy to clear; control ports do not.
				if (cls != cop_pkg::PC_COPROC || !busy_any) begin
					s_next.req = 1'b1;
					s_next.st = H_REQ;
				end
			end
			H_REQ: begin
				if (link.ack) begin
					s_next.req = 1'b0;
					s_next.rdata = link.rdata;
					s_next.pend = 1'b0;
					s_next.ev[cop_pkg::EV_DONE] = 1'b1;
					s_next.st = H_IDLE;
				end
			end
			default: begin
				s_next.st = H_IDLE;
			end
		endcase
		// Events are set after any clear so that a set wins.
		if (link.err_busy && !s_reg.errb_q) begin
			s_next.ev[cop_pkg::EV_ERRB] = 1'b1;
		end
		if (!busy_any && s_reg.busy_q) begin
			s_next.ev[cop_pkg::EV_IDLE] = 1'b1;
		end
		s_next.irq = |(s_next.ev & s_next.en);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// One register for all state, frozen while the enable is low.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_reg <= HOST_RST;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// All outputs come from the state register.
	assign link.req = s_reg.req;
	assign link.wr = s_reg.wr;
	assign link.byte8 = s_reg.byte8;
	assign link.addr = s_reg.addr;
	assign link.wdata = s_reg.wdata;
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign irq = s_reg.irq;

endmodule

// ===== cop_link_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Link protocol checks between host and glue logic
// ------------------------------------------------------------
module cop_link_checker (
	input wire logic clk, // System clock.
	input wire logic nrst, // Reset, active low.
	input wire logic req, // Host request.
	input wire logic wr, // Output cycle.
	input wire logic byte8, // 8-bit cycle.
	input wire logic [7:0] addr, // Port address.
	input wire logic [15:0] rdata, // Input data.
	input wire logic ack, // End of cycle.
	input wire logic busy, // Coprocessor busy.
	input wire logic err_busy, // Latched error busy.
	input wire logic cp_busy, // Raw busy.
	input wire logic cp_error_n // Raw error, active low.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic clr_cyc;
	logic cop_port;
	// Decodes of the cycle now on the link.
	assign clr_cyc = req && wr && byte8 && addr == cop_pkg::PORT_BUSY_CLR;
	assign cop_port = addr inside {cop_pkg::PORT_CP0, cop_pkg::PORT_CP1, cop_pkg::PORT_CP2};
	a_ack_one_cycle: assert property (ack |=> !ack)
		else $error("ack held longer than one cycle");
	a_req_held: assert property (req && !ack |=> req)
		else $error("request dropped before ack");
	a_req_release: assert property (ack |=> !req)
		else $error("request not released after ack");
	a_busy_follow: assert property ($past(nrst) |-> busy == $past(cp_busy))
		else $error("busy does not follow coprocessor busy");
	a_err_sets: assert property (!cp_error_n |=> err_busy)
		else $error("error did not latch busy");
	a_err_holds: assert property (err_busy && !clr_cyc |=> err_busy)
		else $error("latched busy lost without clear");
	a_clear_works: assert property (clr_cyc && ack && cp_error_n && $past(cp_error_n) |=> !err_busy)
		else $error("latched busy not cleared");
	a_cop_ack_lat: assert property ($rose(req) && cop_port |-> ##2 ack)
		else $error("coprocessor port cycle not acked in two cycles");
	a_float_read: assert property ($rose(req) && !wr && addr < cop_pkg::PORT_BUSY_CLR |->
		##1 ack && rdata == cop_pkg::RDATA_FLOAT)
		else $error("unmapped read not floating");
	// Main scenarios reached.
	c_cop_read: cover property ($rose(req) && cop_port && !wr);
	c_clear: cover property (clr_cyc && ack);
	c_err: cover property ($rose(err_busy));
endmodule

// ===== math_coprocessor_io_port_tb.sv
`timescale 1ns/1ps
module math_coprocessor_io_port_tb;
	localparam int RC = 4;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, perr;
	logic cp_sel, cp_wr, cp_rd, cp_byte, cp_reset, s_wr, s_rd, s_by;
	logic [1:0] cp_idx, s_idx;
	logic [15:0] cp_wdata, s_wd;
	logic [15:0] cp_rdata = 16'h0;
	logic cp_busy = 1'h0;
	logic cp_error_n = 1'h1;
	int error_cnt = 0, n_compared = 0, n_strobe = 0, n_rst = 0;

	// Clock of 25 ns period.
	always #12.5 clk = ~clk;

	// ------------------------------------------------------------
	// Both ends joined by the link
	// ------------------------------------------------------------
	cop_link_if cop_link_if_i ();
	cop_glue #(.RESET_CYCLES(RC)) cop_glue_i (.clk(clk), .nrst(nrst), .ce(1'h1),
		.link(cop_link_if_i.dev), .cp_sel(cp_sel), .cp_wr(cp_wr), .cp_rd(cp_rd),
		.cp_idx(cp_idx), .cp_byte(cp_byte), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata),
		.cp_busy(cp_busy), .cp_error_n(cp_error_n), .cp_reset(cp_reset));
	cop_host cop_host_i (.clk(clk), .nrst(nrst), .ce(1'h1), .link(cop_link_if_i.host),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	cop_link_checker cop_link_checker_i (.clk(clk), .nrst(nrst), .req(cop_link_if_i.req),
		.wr(cop_link_if_i.wr), .byte8(cop_link_if_i.byte8), .addr(cop_link_if_i.addr),
		.rdata(cop_link_if_i.rdata), .ack(cop_link_if_i.ack), .busy(cop_link_if_i.busy),
		.err_busy(cop_link_if_i.err_busy), .cp_busy(cp_busy), .cp_error_n(cp_error_n));

	// Records each coprocessor strobe and counts reset pulse cycles.
	always @(posedge clk) begin
		if (cp_sel) begin
			s_wr <= cp_wr;
			s_rd <= cp_rd;
			s_by <= cp_byte;
			s_idx <= cp_idx;
			s_wd <= cp_wdata;
			n_strobe <= n_strobe + 1;
		end
		if (cp_reset)
			n_rst <= n_rst + 1;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	task automatic go(input logic w, input logic b, input logic [7:0] a, input logic [15:0] d);
		apb(1'h1, cop_pkg::REG_ADDR, {24'h0, a});
		apb(1'h1, cop_pkg::REG_WDATA, {16'h0, d});
		apb(1'h1, cop_pkg::REG_CTRL, {29'h0, b, w, 1'h1});
	endtask

	// Polls the pending flag until the I/O cycle has ended.
	task automatic wait_done();
		rd = 32'h1;
		for (int i = 0; i < 40 && rd[cop_pkg::STAT_PEND] !== 1'h0; i++)
			apb(1'h0, cop_pkg::REG_STATUS, 32'h0);
		check(rd[cop_pkg::STAT_PEND], 1'h0);
	endtask

	task automatic io(input logic w, input logic b, input logic [7:0] a, input logic [15:0] d);
		go(w, b, a, d);
		wait_done();
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_ports();
		logic [7:0] a;
		int n;
		apb(1'h0, 8'h40, 32'h0);
		check(perr, 1'h1);
		for (int i = 0; i < 3; i++) begin
			a = 8'hF8 + 8'(2 * i);
			n = n_strobe;
			io(1'h1, 1'h0, a, 16'hA500 + 16'(i));
			check({s_wr, s_idx, s_wd}, {1'h1, 2'(i), 16'hA500 + 16'(i)});
			check({s_rd, s_by}, 2'h0);
			cp_rdata <= 16'h5A00 + 16'(i);
			io(1'h0, 1'h0, a, 16'h0);
			check({s_wr, s_idx}, {1'h0, 2'(i)});
			check(s_rd, 1'h1);
			check(n_strobe - n, 2);
			apb(1'h0, cop_pkg::REG_RDATA, 32'h0);
			check(rd, {16'h0, 16'h5A00 + 16'(i)});
		end
		n = n_strobe;
		io(1'h0, 1'h0, 8'h80, 16'h0);
		apb(1'h0, cop_pkg::REG_RDATA, 32'h0);
		check(rd, {16'h0, cop_pkg::RDATA_FLOAT});
		check(n_strobe - n, 0);
	endtask

	task automatic t_busy();
		int n;
		cp_busy <= 1'h1;
		repeat (3) @(posedge clk);
		n = n_strobe;
		go(1'h1, 1'h1, cop_pkg::PORT_CP0, 16'h0077);
		repeat (20) @(posedge clk);
		check(n_strobe - n, 0);
		apb(1'h0, cop_pkg::REG_STATUS, 32'h0);
		check(rd, 32'h3);
		cp_busy <= 1'h0;
		wait_done();
		check(n_strobe - n, 1);
		check({s_by, s_wd}, {1'h1, 16'h0077});
	endtask

	task automatic t_err();
		int n;
		apb(1'h1, cop_pkg::REG_IRQ_CLR, 32'hF);
		apb(1'h1, cop_pkg::REG_IRQ_EN, 32'h2);
		cp_error_n <= 1'h0;
		@(posedge clk);
		cp_error_n <= 1'h1;
		repeat (30) @(posedge clk);
		apb(1'h0, cop_pkg::REG_STATUS, 32'h0);
		check(rd, 32'h4);
		check(irq, 1'h1);
		n = n_rst;
		io(1'h1, 1'h1, cop_pkg::PORT_CP_RESET, 16'h005A);
		check(n_rst - n, RC);
		n = n_rst;
		io(1'h1, 1'h0, cop_pkg::PORT_CP_RESET, 16'h0);
		check(n_rst - n, 0);
		io(1'h1, 1'h0, cop_pkg::PORT_BUSY_CLR, 16'h0);
		apb(1'h0, cop_pkg::REG_STATUS, 32'h0);
		check(rd, 32'h4);
		io(1'h1, 1'h1, cop_pkg::PORT_BUSY_CLR, 16'h00A5);
		apb(1'h0, cop_pkg::REG_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'h1, cop_pkg::REG_IRQ_CLR, 32'h2);
		repeat (2) @(posedge clk);
		check(irq, 1'h0);
		// A system reset in mid-run empties the busy latch as well.
		cp_error_n <= 1'h0;
		@(posedge clk);
		cp_error_n <= 1'h1;
		apb(1'h0, cop_pkg::REG_STATUS, 32'h0);
		check(rd, 32'h4);
		nrst <= 1'h0;
		@(posedge clk);
		nrst <= 1'h1;
		@(posedge clk);
		apb(1'h0, cop_pkg::REG_STATUS, 32'h0);
		check(rd, 32'h0);
	endtask

	task automatic give_verdict();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Reset for three cycles, then the scenarios.
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		@(posedge clk);
		t_ports();
		t_busy();
		t_err();
		give_verdict();
	end

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
endmodule
